//--- core/amc_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the control block and its bench
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH

// register offsets on the 4-bit address port
`define AMC_OFS_RUN_CTRL   4'h0
`define AMC_OFS_TRIG_MODE  4'h1
`define AMC_OFS_REF_RES    4'h2
`define AMC_OFS_UP_LIMIT   4'h3
`define AMC_OFS_LO_LIMIT   4'h4
`define AMC_OFS_CHAN_SEL   4'h5
`define AMC_OFS_RESULT_LO  4'h6
`define AMC_OFS_RESULT_HI  4'h7
`define AMC_OFS_REQ_FLAGS  4'h8
`define AMC_OFS_MASK_FLAGS 4'h9

// field positions
`define AMC_RUN_BIT    7
`define AMC_CE_BIT     0
`define AMC_TMD_HI     7
`define AMC_TMD_LO     6
`define AMC_SCM_BIT    5
`define AMC_TRS_HI     1
`define AMC_REFP_HI    7
`define AMC_REFM_BIT   5
`define AMC_CRK_BIT    3
`define AMC_AWC_BIT    2
`define AMC_TYP_BIT    0
`define AMC_ISS_BIT    7
`define AMC_ADS_HI     4
`define AMC_REQ_BIT    2

// writable bit masks
`define AMC_WM_RUN   8'h81
`define AMC_WM_TRIG  8'he3
`define AMC_WM_REF   8'hed
`define AMC_WM_CHAN  8'h9f

// reset values
`define AMC_RST_ZERO 8'h00
`define AMC_RST_UP   8'hff
`define AMC_RST_MASK 1'b1

// trigger source codes
`define AMC_TRS_TMR  2'h0
`define AMC_TRS_RTC  2'h2
`define AMC_TRS_ITV  2'h3

// comparator settling time in wait mode, and clock period
`define AMC_STAB_NS  1000
`define AMC_CLK_NS   10
`define AMC_STAB_CYC ((`AMC_STAB_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)

`endif

//--- core/amc_pkg.sv
// types of the converter mode, channel and limit control block
// assumes the defines header for widths of nothing; types only
package amc_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        AMC_IDLE = 2'b00,
        AMC_WAIT = 2'b01,
        AMC_CONV = 2'b10
    } amc_fsm_e;

    // complete state of the control block
    typedef struct packed {
        logic [7:0] run_ctrl;
        logic [7:0] trig_mode;
        logic [7:0] ref_res;
        logic [7:0] up_limit;
        logic [7:0] lo_limit;
        logic [7:0] chan_sel;
        logic [9:0] result;
        logic       req_flag;
        logic       mask_flag;
        logic [7:0] rdata;
        amc_fsm_e   fsm;
        logic [6:0] cnt;
        logic       start;
        logic       irq;
    } amc_state_s;

endpackage

//--- core/amc_ctrl.sv
// converter control: trigger modes, references, limit window, channels
// assumes a converter core on the same clock that pulses done with data
//
// Function
// RULE1 - two-bit field picks software or hardware trigger
// RULE2 - conversion-mode bit: 0 repeats, 1 one-shot
// RULE3 - source field picks timer, clock or interval trigger
// RULE4 - positive reference: supply, pin, internal, 11 barred; the code passes 11 to POS_REF_O
// RULE5 - negative reference: ground or external pin
// RULE6 - polarity 0: interrupt when result inside window
// RULE7 - polarity 1: interrupt when result outside window
// RULE8 - wake-up bit enables snooze wake-up
// RULE9 - resolution bit: 0 ten-bit, 1 eight-bit
// RULE10 - two writable 8-bit upper and lower limits
// RULE11 - external channel codes 0-3 and 16-22
// RULE12 - internal codes: temperature sensor, internal reference
// RULE13 - hardware sets request flag, software clears it
// RULE14 - mask bit 1 blocks conversion-end interrupt
// RULE15 - comparator runs only while enable bit set
// RULE16 - conversions only while run bit set
// RULE17 - software sequential mode repeats conversions continuously
// RULE18 - hardware modes start on each selected trigger; the code ignores triggers that come during wait or conversion
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "amc_defines.svh"

module amc_ctrl
    import amc_pkg::*;
(
    input  wire logic       REF_CLK_I,     // 100 MHz clock
    input  wire logic       RST_N_I,       // sync reset, low
    input  wire logic [3:0] ADDR_I,        // register address
    input  wire logic [7:0] WDATA_I,       // write data
    input  wire logic       WR_I,          // write strobe
    input  wire logic       RD_I,          // read strobe
    output logic      [7:0] RDATA_O,       // read data, next cycle
    input  wire logic       TMR_TRIG_I,    // timer channel interrupt
    input  wire logic       RTC_TRIG_I,    // real-time clock interrupt
    input  wire logic       ITV_TRIG_I,    // interval timer interrupt
    input  wire logic       CONV_DONE_I,   // core conversion done pulse
    input  wire logic [9:0] CONV_DATA_I,   // core result with done
    output logic            CONV_START_O,  // start one conversion
    output logic            COMP_EN_O,     // comparator enable
    output logic      [4:0] CHAN_O,        // channel code
    output logic            INT_SRC_O,     // internal source select
    output logic      [1:0] POS_REF_O,     // positive reference select
    output logic            NEG_REF_O,     // negative reference select
    output logic            RES8_O,        // eight-bit resolution
    output logic            SNOOZE_EN_O,   // snooze wake-up enable
    output logic            BUSY_O,        // settle wait or conversion in progress
    output logic            IRQ_O          // conversion-end interrupt
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    localparam logic [6:0] STAB_LAST = 7'(`AMC_STAB_CYC - 1);

    // legal channel code for the selected source
    function automatic logic chan_ok(input logic [7:0] c);
        logic [4:0] a;
        a = c[`AMC_ADS_HI:0];
        if (c[`AMC_ISS_BIT])
            chan_ok = (a == 5'h00) || (a == 5'h01); // [RULE12]
        else
            chan_ok = (a <= 5'h03) || ((a >= 5'h10) && (a <= 5'h16)); // [RULE11]
    endfunction

    // limit check on the upper eight result bits
    function automatic logic win_pass(input logic [9:0] r,
                                      input logic       crk,
                                      input logic [7:0] ul,
                                      input logic [7:0] ll);
        logic in_win;
        in_win = (r[9:2] >= ll) && (r[9:2] <= ul); // [RULE10]
        if (crk)
            win_pass = !in_win; // [RULE7]
        else
            win_pass = in_win; // [RULE6]
    endfunction

    // result as stored for the chosen resolution
    function automatic logic [9:0] fit_res(input logic [9:0] d,
                                           input logic       typ);
        fit_res = typ ? {d[9:2], 2'b00} : d; // [RULE9]
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    amc_state_s s;
    amc_state_s n;
    logic       sw_mode;
    logic       wait_mode;
    logic       trig_hit;
    logic       go;
    logic [9:0] new_res;

    // trigger mode decode and source select
    always_comb
    begin
        sw_mode   = !s.trig_mode[`AMC_TMD_HI]; // [RULE1]
        wait_mode = s.trig_mode[`AMC_TMD_HI] && s.trig_mode[`AMC_TMD_LO]; // [RULE1]
        case (s.trig_mode[`AMC_TRS_HI:0]) // [RULE3]
            `AMC_TRS_TMR: trig_hit = TMR_TRIG_I;
            `AMC_TRS_RTC: trig_hit = RTC_TRIG_I;
            `AMC_TRS_ITV: trig_hit = ITV_TRIG_I;
            default:      trig_hit = 1'b0;
        endcase
        go = s.run_ctrl[`AMC_RUN_BIT] && s.run_ctrl[`AMC_CE_BIT] // [RULE15] [RULE16]
             && chan_ok(s.chan_sel);
        new_res = fit_res(CONV_DATA_I, s.ref_res[`AMC_TYP_BIT]);
    end

    ////////////////////////////////////////////////////////////////////
    // next state: bus, sequencer, flag

    always_comb
    begin
        n       = s;
        n.start = 1'b0;
        n.rdata = `AMC_RST_ZERO;
        // register writes
        if (WR_I)
        begin
            case (ADDR_I)
                `AMC_OFS_RUN_CTRL:   n.run_ctrl  = WDATA_I & `AMC_WM_RUN;
                `AMC_OFS_TRIG_MODE:  n.trig_mode = WDATA_I & `AMC_WM_TRIG;
                `AMC_OFS_REF_RES:    n.ref_res   = WDATA_I & `AMC_WM_REF;
                `AMC_OFS_UP_LIMIT:   n.up_limit  = WDATA_I; // [RULE10]
                `AMC_OFS_LO_LIMIT:   n.lo_limit  = WDATA_I; // [RULE10]
                `AMC_OFS_CHAN_SEL:   n.chan_sel  = WDATA_I & `AMC_WM_CHAN;
                `AMC_OFS_REQ_FLAGS:  n.req_flag  = WDATA_I[`AMC_REQ_BIT]; // [RULE13]
                `AMC_OFS_MASK_FLAGS: n.mask_flag = WDATA_I[`AMC_REQ_BIT];
                default:             n.mask_flag = s.mask_flag;
            endcase
        end
        // register reads, flag register clears on read
        if (RD_I)
        begin
            case (ADDR_I)
                `AMC_OFS_RUN_CTRL:   n.rdata = s.run_ctrl;
                `AMC_OFS_TRIG_MODE:  n.rdata = s.trig_mode;
                `AMC_OFS_REF_RES:    n.rdata = s.ref_res;
                `AMC_OFS_UP_LIMIT:   n.rdata = s.up_limit;
                `AMC_OFS_LO_LIMIT:   n.rdata = s.lo_limit;
                `AMC_OFS_CHAN_SEL:   n.rdata = s.chan_sel;
                `AMC_OFS_RESULT_LO:  n.rdata = s.result[7:0];
                `AMC_OFS_RESULT_HI:  n.rdata = {6'h00, s.result[9:8]};
                `AMC_OFS_REQ_FLAGS:  n.rdata = {5'h00, s.req_flag, 2'h0};
                `AMC_OFS_MASK_FLAGS: n.rdata = {5'h00, s.mask_flag, 2'h0};
                default:             n.rdata = `AMC_RST_ZERO;
            endcase
            if (ADDR_I == `AMC_OFS_REQ_FLAGS)
                n.req_flag = 1'b0;
        end
        // conversion sequencer
        case (s.fsm)
            AMC_IDLE:
            begin
                if (go && sw_mode)
                begin
                    n.start = 1'b1;
                    n.fsm   = AMC_CONV;
                end
                else if (go && trig_hit) // [RULE18]
                begin
                    if (wait_mode)
                    begin
                        n.cnt = 7'h00;
                        n.fsm = AMC_WAIT;
                    end
                    else
                    begin
                        n.start = 1'b1;
                        n.fsm   = AMC_CONV;
                    end
                end
            end
            AMC_WAIT:
            begin
                // comparator settles before the sample in wait mode
                if (s.cnt == STAB_LAST)
                begin
                    n.start = 1'b1;
                    n.fsm   = AMC_CONV;
                end
                else
                    n.cnt = s.cnt + 7'h01;
            end
            AMC_CONV:
            begin
                if (CONV_DONE_I)
                begin
                    n.result = new_res;
                    if (win_pass(new_res, s.ref_res[`AMC_CRK_BIT],
                                 s.up_limit, s.lo_limit))
                        n.req_flag = 1'b1; // [RULE13]
                    if (!s.trig_mode[`AMC_SCM_BIT]) // [RULE2] [RULE17]
                    begin
                        n.start = 1'b1;
                        n.fsm   = AMC_CONV;
                    end
                    else
                    begin
                        n.fsm = AMC_IDLE;
                        if (sw_mode)
                            n.run_ctrl[`AMC_RUN_BIT] = 1'b0; // [RULE2]
                    end
                end
            end
            default:
                n.fsm = AMC_IDLE;
        endcase
        // stop or abort when run, comparator or channel drops; a write that
        // drops one of them in the start cycle wins over the start
        if (!go || !(n.run_ctrl[`AMC_RUN_BIT] && n.run_ctrl[`AMC_CE_BIT]
                     && chan_ok(n.chan_sel)))
        begin
            n.start = 1'b0; // [RULE15] [RULE16]
            n.fsm   = AMC_IDLE;
        end
        n.irq = n.req_flag && !n.mask_flag; // [RULE14]
    end

    // state register
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            s           <= '0;
            s.up_limit  <= `AMC_RST_UP;
            s.mask_flag <= `AMC_RST_MASK;
            s.fsm       <= AMC_IDLE;
        end
        else
            s <= n;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from the state register

    assign RDATA_O      = s.rdata;
    assign CONV_START_O = s.start;
    assign COMP_EN_O    = s.run_ctrl[`AMC_CE_BIT]; // [RULE15]
    assign CHAN_O       = s.chan_sel[`AMC_ADS_HI:0]; // [RULE11]
    assign INT_SRC_O    = s.chan_sel[`AMC_ISS_BIT]; // [RULE12]
    assign POS_REF_O    = s.ref_res[`AMC_REFP_HI:`AMC_REFP_HI-1]; // [RULE4]
    assign NEG_REF_O    = s.ref_res[`AMC_REFM_BIT]; // [RULE5]
    assign RES8_O       = s.ref_res[`AMC_TYP_BIT]; // [RULE9]
    assign SNOOZE_EN_O  = s.ref_res[`AMC_AWC_BIT]; // [RULE8]
    assign BUSY_O       = (s.fsm != AMC_IDLE);
    assign IRQ_O        = s.irq;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // a start only while run and comparator are on
    start_needs_run_a: assert property ( // [RULE16]
        CONV_START_O |-> s.run_ctrl[`AMC_RUN_BIT] && COMP_EN_O)
        else $error("start without run and comparator");

    // comparator off forbids any start next cycle
    comp_off_a: assert property ( // [RULE15]
        !COMP_EN_O && !WR_I |=> !CONV_START_O)
        else $error("start with comparator off");

    // software sequential restarts right after done
    seq_repeat_a: assert property ( // [RULE17]
        s.fsm == AMC_CONV && CONV_DONE_I && go && sw_mode
        && !s.trig_mode[`AMC_SCM_BIT] && !WR_I |=> CONV_START_O)
        else $error("sequential mode did not restart");

    // software one-shot drops the run bit after done
    oneshot_stop_a: assert property ( // [RULE2]
        s.fsm == AMC_CONV && CONV_DONE_I && go && sw_mode
        && s.trig_mode[`AMC_SCM_BIT] && !WR_I
        |=> !s.run_ctrl[`AMC_RUN_BIT] && !CONV_START_O ##1 !CONV_START_O)
        else $error("one-shot did not stop");

    // hardware modes wait for the selected trigger
    hw_trig_wait_a: assert property ( // [RULE18]
        s.fsm == AMC_IDLE && !sw_mode && !trig_hit |=> !CONV_START_O)
        else $error("hardware start without trigger");

    // no-wait mode starts the cycle after the trigger
    hw_nowait_a: assert property ( // [RULE1]
        s.fsm == AMC_IDLE && go && !sw_mode && !wait_mode && trig_hit
        && !WR_I |=> CONV_START_O)
        else $error("no-wait trigger did not start");

    // wait mode holds the start for the first two cycles after the trigger
    hw_wait_a: assert property ( // [RULE1]
        s.fsm == AMC_IDLE && go && wait_mode && trig_hit && !WR_I
        |=> !CONV_START_O ##1 !CONV_START_O)
        else $error("wait mode started too early");

    // passing result sets the request flag
    win_set_a: assert property ( // [RULE6]
        s.fsm == AMC_CONV && CONV_DONE_I && go
        && win_pass(new_res, s.ref_res[`AMC_CRK_BIT], s.up_limit, s.lo_limit)
        |=> s.req_flag)
        else $error("window pass did not set flag");

    // failing result leaves a clear flag clear
    win_fail_a: assert property ( // [RULE7]
        s.fsm == AMC_CONV && CONV_DONE_I && !s.req_flag && !WR_I
        && !win_pass(new_res, s.ref_res[`AMC_CRK_BIT], s.up_limit, s.lo_limit)
        |=> !s.req_flag)
        else $error("window fail set flag");

    // masked flag never reaches the interrupt
    irq_mask_a: assert property ( // [RULE14]
        IRQ_O |-> s.req_flag && !s.mask_flag ##1 (IRQ_O || !s.req_flag || s.mask_flag))
        else $error("interrupt while masked or no flag");

    // run cleared returns the sequencer to idle
    run_stop_a: assert property ( // [RULE16]
        !s.run_ctrl[`AMC_RUN_BIT] && !WR_I |=> !BUSY_O)
        else $error("busy after run cleared");

    // comparator off returns the sequencer to idle
    comp_idle_a: assert property ( // [RULE15]
        !COMP_EN_O |=> !BUSY_O)
        else $error("busy with comparator off");

    // a barred channel code never starts a conversion
    chan_block_a: assert property ( // [RULE11]
        !chan_ok(s.chan_sel) |=> !CONV_START_O)
        else $error("start on a barred channel");

    // the barred source code never triggers
    src_barred_a: assert property ( // [RULE3]
        s.fsm == AMC_IDLE && !sw_mode && s.trig_mode[`AMC_TRS_HI:0] == 2'b01
        |=> !CONV_START_O)
        else $error("start from the barred trigger source");

    // wait mode holds the start until the settle count ends
    wait_hold_a: assert property ( // [RULE1]
        s.fsm == AMC_WAIT && s.cnt != STAB_LAST |=> !CONV_START_O)
        else $error("wait mode start before settle count");

    // eight-bit results keep the two low bits clear
    res8_low_a: assert property ( // [RULE9]
        s.fsm == AMC_CONV && CONV_DONE_I && RES8_O |=> s.result[1:0] == 2'b00)
        else $error("eight-bit result has low bits set");

    // upper limit writes land in full on the next edge
    upper_write_a: assert property ( // [RULE10]
        WR_I && ADDR_I == `AMC_OFS_UP_LIMIT |=> s.up_limit == $past(WDATA_I))
        else $error("upper limit write lost");

    // lower limit writes land in full on the next edge
    lower_write_a: assert property ( // [RULE10]
        WR_I && ADDR_I == `AMC_OFS_LO_LIMIT |=> s.lo_limit == $past(WDATA_I))
        else $error("lower limit write lost");

    // a read of the flag register clears it unless a result lands
    flag_clear_a: assert property ( // [RULE13]
        RD_I && !WR_I && ADDR_I == `AMC_OFS_REQ_FLAGS
        && !(s.fsm == AMC_CONV && CONV_DONE_I) |=> !s.req_flag)
        else $error("flag read did not clear");

    // the request flag rises only on a conversion end or a write
    flag_source_a: assert property ( // [RULE13]
        !s.req_flag && !WR_I && !(s.fsm == AMC_CONV && CONV_DONE_I)
        |=> !s.req_flag)
        else $error("request flag set without a cause");

    // mask writes land on the next edge
    mask_write_a: assert property ( // [RULE14]
        WR_I && ADDR_I == `AMC_OFS_MASK_FLAGS
        |=> s.mask_flag == $past(WDATA_I[`AMC_REQ_BIT]))
        else $error("mask write lost");

endmodule

//--- verif/amc_ctrl_tb.sv
// self-checking bench for the converter mode, channel and limit control block
// assumes the design files under core/ and a 100 MHz clock; the bench plays the core
`timescale 1ns/1ps
`include "amc_defines.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module amc_ctrl_tb;

    typedef struct packed {
        logic [3:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } amc_row_s;
    typedef struct packed {
        logic       p;
        logic [9:0] d;
        logic       f;
    } amc_win_s;

    logic       clk;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] trg;
    logic       done;
    logic [9:0] data;
    logic       start;
    logic       comp_en;
    logic [4:0] chan;
    logic       int_src;
    logic [1:0] pos_ref;
    logic       neg_ref;
    logic       res8;
    logic       snooze;
    logic       busy;
    logic       irq;
    int         miscompares;
    int         compares;
    int         cyc;
    int         i;
    int         k;
    amc_row_s   rows [12];
    amc_win_s   win [8];

    ////////////////////////////////////////////////////////////////////////////
    // device under test
    amc_ctrl i_amc_ctrl (
        .REF_CLK_I    (clk),
        .RST_N_I      (rst_n),
        .ADDR_I       (addr),
        .WDATA_I      (wdata),
        .WR_I         (wr),
        .RD_I         (rd),
        .RDATA_O      (rdata),
        .TMR_TRIG_I   (trg[0]),
        .RTC_TRIG_I   (trg[1]),
        .ITV_TRIG_I   (trg[2]),
        .CONV_DONE_I  (done),
        .CONV_DATA_I  (data),
        .CONV_START_O (start),
        .COMP_EN_O    (comp_en),
        .CHAN_O       (chan),
        .INT_SRC_O    (int_src),
        .POS_REF_O    (pos_ref),
        .NEG_REF_O    (neg_ref),
        .RES8_O       (res8),
        .SNOOZE_EN_O  (snooze),
        .BUSY_O       (busy),
        .IRQ_O        (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            miscompares++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus, trigger and core tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    task automatic pulse_trg(input logic [2:0] t);
        @(posedge clk);
        trg <= t;
        @(posedge clk);
        trg <= 3'b000;
        #1;
    endtask

    // bounded wait for a start pulse; k counts the edges waited
    task automatic wstart(input int n);
        k = 0;
        while (k < n && start !== 1'b1)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    // core returns one result; then interrupt level and sticky flag are checked
    task automatic conv(input logic [9:0] d, input logic f, input logic ei, input string nm);
        `CHK("busy", 1'b1, busy)
        @(posedge clk);
        done <= 1'b1;
        data <= d;
        @(posedge clk);
        done <= 1'b0;
        tick(2);
        `CHK(nm, ei, irq)
        rreg(`AMC_OFS_REQ_FLAGS, {5'h0, f, 2'h0}, nm);
    endtask

    task automatic chk_rst;
        rreg(`AMC_OFS_RUN_CTRL, 8'h00, "run");
        rreg(`AMC_OFS_TRIG_MODE, 8'h00, "trig");
        rreg(`AMC_OFS_REF_RES, 8'h00, "ref");
        rreg(`AMC_OFS_UP_LIMIT, 8'hff, "ul");
        rreg(`AMC_OFS_LO_LIMIT, 8'h00, "ll");
        rreg(`AMC_OFS_CHAN_SEL, 8'h00, "chan");
        rreg(`AMC_OFS_MASK_FLAGS, 8'h04, "mask");
        `CHK("rst", 2'b00, {irq, busy})
    endtask

    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rows = '{20'h1ffe3, 20'h10000, 20'h2ffed, 20'h20000, 20'h35a5a, 20'h4a5a5,
                 20'h5ff9f, 20'h58181, 20'h90000, 20'h9ff04, 20'haff00, 20'h6ff00};
        win  = '{'{1'b0, 10'h040, 1'b1}, '{1'b0, 10'h200, 1'b1},
                 '{1'b0, 10'h03c, 1'b0}, '{1'b0, 10'h204, 1'b0},
                 '{1'b1, 10'h03c, 1'b1}, '{1'b1, 10'h204, 1'b1},
                 '{1'b1, 10'h040, 1'b0}, '{1'b1, 10'h200, 1'b0}};
        {rst_n, addr, wdata, wr, rd, trg, done, data} = '0;
        {miscompares, compares, cyc} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_rst();
        // register map rows: write then read back
        for (i = 0; i < 12; i++)
        begin
            wreg(rows[i].a, rows[i].w);
            rreg(rows[i].a, rows[i].e, "reg");
        end
        wreg(`AMC_OFS_REF_RES, 8'hff);
        wreg(`AMC_OFS_CHAN_SEL, 8'h96);
        tick(1);
        `CHK("refs", 5'h1f, {pos_ref, neg_ref, snooze, res8})
        `CHK("chan", 6'h36, {int_src, chan})
        wreg(`AMC_OFS_REF_RES, 8'h40);
        tick(1);
        `CHK("refs", 5'h08, {pos_ref, neg_ref, snooze, res8})
        // software sequential, window boundaries in both polarities
        wreg(`AMC_OFS_UP_LIMIT, 8'h80);
        wreg(`AMC_OFS_LO_LIMIT, 8'h10);
        wreg(`AMC_OFS_CHAN_SEL, 8'h00);
        wreg(`AMC_OFS_MASK_FLAGS, 8'h00);
        wreg(`AMC_OFS_TRIG_MODE, 8'h00);
        wreg(`AMC_OFS_REF_RES, 8'h00);
        wreg(`AMC_OFS_RUN_CTRL, 8'h81);
        wstart(5);
        `CHK("start", 1'b1, start)
        for (i = 0; i < 8; i++)
        begin
            if (i == 4)
                wreg(`AMC_OFS_REF_RES, {4'h0, win[i].p, 3'h0});
            conv(win[i].d, win[i].f, win[i].f, "window");
        end
        rreg(`AMC_OFS_RESULT_LO, 8'h00, "res_lo");
        rreg(`AMC_OFS_RESULT_HI, 8'h02, "res_hi");
        wreg(`AMC_OFS_MASK_FLAGS, 8'hff);
        conv(10'h3fc, 1'b1, 1'b0, "masked");
        wreg(`AMC_OFS_MASK_FLAGS, 8'h00);
        wreg(`AMC_OFS_REF_RES, 8'h01);
        conv(10'h3ff, 1'b0, 1'b0, "res8");
        rreg(`AMC_OFS_RESULT_LO, 8'hfc, "res_lo");
        rreg(`AMC_OFS_RESULT_HI, 8'h03, "res_hi");
        // stop, comparator off, prohibited channel
        wreg(`AMC_OFS_RUN_CTRL, 8'h00);
        tick(3);
        `CHK("busy", 1'b0, busy)
        wreg(`AMC_OFS_RUN_CTRL, 8'h80);
        wstart(10);
        `CHK("ce_off", 2'b00, {start, comp_en})
        wreg(`AMC_OFS_CHAN_SEL, 8'h04);
        wreg(`AMC_OFS_RUN_CTRL, 8'h81);
        wstart(10);
        `CHK("bad_chan", 2'b01, {start, comp_en})
        // one-shot on the temperature sensor channel
        wreg(`AMC_OFS_RUN_CTRL, 8'h00);
        wreg(`AMC_OFS_TRIG_MODE, 8'h20);
        wreg(`AMC_OFS_CHAN_SEL, 8'h80);
        wreg(`AMC_OFS_RUN_CTRL, 8'h81);
        wstart(5);
        `CHK("start", 1'b1, start)
        conv(10'h100, 1'b1, 1'b1, "oneshot");
        wstart(10);
        `CHK("idle", 2'b00, {start, busy})
        rreg(`AMC_OFS_RUN_CTRL, 8'h01, "run");
        // hardware no-wait one-shot, each source; wrong sources ignored
        for (i = 0; i < 3; i++)
        begin
            wreg(`AMC_OFS_TRIG_MODE, 8'ha0 | (i == 0 ? 8'h00 : 8'(i + 1)));
            wreg(`AMC_OFS_RUN_CTRL, 8'h81);
            wstart(5);
            `CHK("hw_idle", 1'b0, start)
            pulse_trg(3'b111 ^ 3'(1 << i));
            wstart(4);
            `CHK("wrong_src", 1'b0, start)
            pulse_trg(3'(1 << i));
            wstart(3);
            `CHK("hw_start", 1'b1, start)
            conv(10'h100, 1'b1, 1'b1, "hw");
        end
        wreg(`AMC_OFS_TRIG_MODE, 8'ha1);
        pulse_trg(3'b111);
        wstart(10);
        `CHK("src01", 1'b0, start)
        // hardware wait mode: start only after the settle time
        wreg(`AMC_OFS_TRIG_MODE, 8'he0);
        pulse_trg(3'b001);
        wstart(300);
        `CHK("wait_len", 1'b1, start && k >= `AMC_STAB_CYC && k <= `AMC_STAB_CYC + 2)
        conv(10'h100, 1'b1, 1'b1, "wait");
        // reset in mid-run
        wreg(`AMC_OFS_TRIG_MODE, 8'h00);
        wreg(`AMC_OFS_RUN_CTRL, 8'h81);
        tick(3);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_rst();
        stop_test();
    end

endmodule
